// ---- hdl/pci_port.sv ----
`timescale 1ns/1ps
module pci_port import pci_pkg::*; #(
  parameter bit TWO_EVENT = 1'b1,
  parameter bit COMPAT = 1'b0,
  parameter logic [7:0] CUT_C1 = 8'h10,
  parameter logic [7:0] CUT_C2 = 8'h20,
  parameter logic [7:0] CUT_C3 = 8'h30,
  parameter logic [7:0] CUT_C4 = 8'h50,
  parameter int CLASS_CYC = CLASS_TIME_US * CLK_MHZ,
  parameter int MARK_CYC = MARK_TIME_US * CLK_MHZ,
  parameter int TSTART_CYC = TSTART_US * CLK_MHZ,
  parameter int BACKOFF_CYC = BACKOFF_US * CLK_MHZ
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // front end pins
  input wire pci_pins_t pins,
  output pci_drive_t drive,
  output logic [7:0] overcurrent_cut_threshold,
  output logic [7:0] active_current_limit_threshold
);
  typedef enum logic [3:0] {
    S_IDLE, S_DETECT, S_CLASS1, S_MARK, S_CLASS2,
    S_BACKOFF, S_INRUSH, S_POWERED
  } pci_state_t;

  // byte-lane merge for register writes
  function automatic logic [15:0] merge(input logic [15:0] old,
      input logic [15:0] nw, input logic [1:0] strb);
    merge = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
  endfunction

  // thresholds implied by a class result
  function automatic logic [15:0] thr_for(input logic [2:0] cls,
      input logic rs);
    logic [7:0] l425;
    l425 = rs ? LIM_425_R50 : LIM_425_R25;
    case (cls)
      CLS_1: thr_for = {l425, CUT_C1};
      CLS_2: thr_for = {l425, CUT_C2};
      CLS_4: thr_for = {rs ? LIM_850_R50 : LIM_850_R25, CUT_C4};
      default: thr_for = {l425, CUT_C3}; // class 0 handled as 3, see R5
    endcase
  endfunction

  // timer load for each state
  function automatic logic [TMR_W-1:0] dur(input pci_state_t s);
    case (s)
      S_CLASS1, S_CLASS2: dur = TMR_W'(CLASS_CYC - 1);
      S_MARK: dur = TMR_W'(MARK_CYC - 1);
      S_INRUSH: dur = TMR_W'(TSTART_CYC - 1);
      S_BACKOFF: dur = TMR_W'(BACKOFF_CYC - 1);
      default: dur = '0;
    endcase
  endfunction

  // ---- pin synchroniser: three stages, accept when 2nd and 3rd agree
  pci_pins_t s1, s2, s3, pf, next_pf;
  always_comb begin
    next_pf = (s2 & s3) | (pf & (s2 | s3));
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      pf <= '0;
    end else begin
      s1 <= pins;
      s2 <= s1;
      s3 <= s2;
      pf <= next_pf;
    end
  end

  // ---- declarations shared between groups
  pci_ctrl_t ctrl, next_ctrl;
  logic [15:0] thresh, next_thresh;
  logic [3:0] cmd;
  logic hp_clr, fault_clr;
  pci_state_t state, next_state;
  logic [TMR_W-1:0] tmr, next_tmr;
  logic [2:0] det_res, next_det_res, cls_f, next_cls_f;
  logic second, next_second, fault, next_fault, done_d;
  logic auto_strap, next_auto_strap;
  logic [2:0] strap_cnt, next_strap_cnt;
  logic strap_load, load_thr;
  logic [2:0] load_cls;
  logic tmr_done, good, det_evt, cls_active, auto_mode, user_on;

  // ---- port sequencer
  always_comb begin
    tmr_done = (tmr == '0);
    auto_mode = (ctrl.mode == MODE_AUTO) && auto_strap;
    good = pf.sig_valid || (ctrl.legacy_en && pf.sig_legacy); // see R2
    det_evt = pf.det_done && !done_d;
    // strap low, shutdown or enable clear keeps class off, see R7
    cls_active = auto_strap && (ctrl.mode != MODE_SHUT) && ctrl.cls_en;
    user_on = (ctrl.mode == MODE_MAN) || (ctrl.mode == MODE_SEMI);
    next_state = state;
    next_det_res = det_res;
    next_cls_f = cls_f;
    next_second = second || (state == S_MARK && tmr_done); // see R11
    if (hp_clr && !(state == S_MARK && tmr_done)) begin
      next_second = 1'b0;
    end
    next_fault = fault && !fault_clr;
    next_auto_strap = auto_strap;
    next_strap_cnt = strap_cnt;
    strap_load = 1'b0;
    load_thr = 1'b0;
    load_cls = pf.class_code;
    // strap taken once, when stages 2 and 3 first hold it after release;
    // later pin changes are ignored until the next reset
    if (strap_cnt != 3'(STRAP_WAIT + 1)) begin
      next_strap_cnt = strap_cnt + 3'h1;
    end
    strap_load = (strap_cnt == 3'(STRAP_WAIT));
    if (strap_load) begin
      next_auto_strap = next_pf.auto_pin;
    end
    case (state)
      S_IDLE: begin
        if (ctrl.mode == MODE_MAN) begin
          if (cmd[CMD_DET]) begin
            next_state = S_DETECT; // one run per command, see R19
          end else if (cmd[CMD_CLS] && cls_active) begin
            next_state = S_CLASS1; // manual class on command, see R3
          end
        end else if (ctrl.mode != MODE_SHUT && ctrl.det_en) begin
          next_state = S_DETECT;
        end
      end
      S_DETECT: begin
        if (det_evt) begin
          next_det_res = good ? DET_GOOD : DET_BAD;
          if (good && cls_active && ctrl.mode != MODE_MAN) begin
            next_state = S_CLASS1; // see R3
          end else if (good && auto_mode) begin
            next_state = S_INRUSH;
          end else if (ctrl.mode == MODE_MAN) begin
            next_state = S_IDLE; // see R19
          end else begin
            next_state = S_BACKOFF;
          end
        end
      end
      S_CLASS1, S_CLASS2: begin
        if (tmr_done) begin
          next_cls_f = pf.class_code; // latest pulse wins, see R4 R15
          if (state == S_CLASS1 && pf.class_code == CLS_4 && ctrl.hp_en
              && TWO_EVENT) begin
            next_state = S_MARK; // see R8 R10 R12 R13
          end else if (ctrl.mode == MODE_MAN) begin
            next_state = S_IDLE;
          end else if (!auto_mode) begin
            next_state = S_BACKOFF;
          end else if (state == S_CLASS2 && pf.class_code != CLS_4) begin
            next_state = S_BACKOFF; // invalid pair withholds power, see R14
          end else begin
            next_state = S_INRUSH; // see R14
            load_thr = 1'b1; // see R6
          end
        end
      end
      S_MARK: begin
        if (tmr_done) begin
          next_state = S_CLASS2; // see R10
        end
      end
      S_BACKOFF: begin
        if (tmr_done) begin
          next_state = S_IDLE;
        end
      end
      S_INRUSH: begin
        if (tmr_done) begin
          if (pf.over_inrush) begin
            next_state = S_IDLE; // see R17
            next_fault = 1'b1;
          end else begin
            next_state = S_POWERED;
          end
        end
      end
      S_POWERED: next_state = S_POWERED;
      default: next_state = S_IDLE;
    endcase
    if (cmd[CMD_ON] && user_on && state != S_INRUSH && state != S_POWERED) begin
      next_state = S_INRUSH; // see R16
    end
    if (cmd[CMD_OFF] || ctrl.mode == MODE_SHUT) begin
      next_state = S_IDLE;
    end
    if (next_state != state) begin
      next_tmr = dur(next_state);
    end else begin
      next_tmr = tmr_done ? tmr : tmr - TMR_W'(1);
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= S_IDLE;
      tmr <= '0;
      det_res <= DET_UNKNOWN;
      cls_f <= CLS_UNKNOWN; // see R20
      second <= 1'b0;
      fault <= 1'b0;
      done_d <= 1'b0;
      auto_strap <= 1'b0;
      strap_cnt <= 3'h0;
    end else begin
      state <= next_state;
      tmr <= next_tmr;
      det_res <= next_det_res;
      cls_f <= next_cls_f;
      second <= next_second;
      fault <= next_fault;
      done_d <= pf.det_done;
      auto_strap <= next_auto_strap;
      strap_cnt <= next_strap_cnt;
    end
  end

  // ---- axi4-lite slave and register file
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [7:0] aw_q, next_aw_q;
  logic [31:0] w_q, next_w_q, next_rdata;
  logic [3:0] strb_q, next_strb_q;
  logic next_bvalid, next_rvalid, wr_fire, rd_take, rd_hit;
  logic [1:0] next_bresp, next_rresp;
  always_comb begin
    wr_fire = aw_held && w_held && !bvalid;
    rd_take = arvalid && arready;
    next_aw_held = aw_held;
    next_aw_q = aw_q;
    next_w_held = w_held;
    next_w_q = w_q;
    next_strb_q = strb_q;
    if (awvalid && awready) begin
      next_aw_held = 1'b1;
      next_aw_q = awaddr;
    end
    if (wvalid && wready) begin
      next_w_held = 1'b1;
      next_w_q = wdata;
      next_strb_q = wstrb;
    end
    next_ctrl = ctrl;
    next_thresh = thresh;
    cmd = '0;
    hp_clr = 1'b0;
    fault_clr = 1'b0;
    next_bvalid = bvalid && !bready;
    next_bresp = bresp;
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      case (aw_q)
        REG_CTRL: next_ctrl = pci_ctrl_t'(7'(merge({9'h0, ctrl},
            w_q[15:0], strb_q[1:0])));
        REG_CMD: cmd = strb_q[0] ? w_q[3:0] : 4'h0;
        REG_THRESH: next_thresh = merge(thresh, w_q[15:0], strb_q[1:0]);
        REG_STATUS: fault_clr = strb_q[1] && w_q[ST_FAULT_BIT];
        REG_HPSTAT: hp_clr = strb_q[0] && w_q[0];
        REG_INFO: next_bresp = RESP_OKAY;
        default: next_bresp = RESP_SLVERR;
      endcase
    end
    // host may change thresholds in any cycle but a class load (load_thr), even while powered, see R9
    if (load_thr) begin
      next_thresh = thr_for(load_cls, ctrl.rsense_large); // see R6
    end
    if (strap_load && next_pf.auto_pin) begin
      next_ctrl.mode = MODE_AUTO;
      next_ctrl.det_en = 1'b1;
      next_ctrl.cls_en = 1'b1;
    end
    rd_hit = 1'b1;
    case (araddr)
      REG_CTRL: next_rdata = {25'h0, ctrl};
      REG_THRESH: next_rdata = {16'h0, thresh};
      REG_STATUS: next_rdata = {22'h0, fault, (state == S_INRUSH ||
          state == S_POWERED), 1'b0, cls_f, 1'b0, det_res};
      REG_HPSTAT: next_rdata = {31'h0, second};
      REG_INFO: next_rdata = {30'h0, auto_strap, TWO_EVENT};
      REG_CMD: next_rdata = 32'h0;
      default: begin
        next_rdata = 32'h0;
        rd_hit = 1'b0;
      end
    endcase
    next_rvalid = rvalid && !rready;
    next_rresp = rresp;
    if (rd_take) begin
      next_rvalid = 1'b1;
      next_rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else begin
      next_rdata = rdata;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // larger sense resistor is default in compatibility build, see R18
      ctrl <= '{rsense_large: COMPAT, hp_en: 1'b0, legacy_en: 1'b0,
          cls_en: 1'b0, det_en: 1'b0, mode: MODE_SHUT}; // see R1
      thresh <= 16'h0000;
      aw_held <= 1'b0;
      aw_q <= 8'h00;
      w_held <= 1'b0;
      w_q <= 32'h0000_0000;
      strb_q <= 4'h0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rresp <= RESP_OKAY;
      rdata <= 32'h0000_0000;
    end else begin
      ctrl <= next_ctrl;
      thresh <= next_thresh;
      aw_held <= next_aw_held;
      aw_q <= next_aw_q;
      w_held <= next_w_held;
      w_q <= next_w_q;
      strb_q <= next_strb_q;
      awready <= !next_aw_held && !(awvalid && awready);
      wready <= !next_w_held && !(wvalid && wready);
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= !next_rvalid && !rd_take;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
    end
  end

  // ---- registered front end drive; inrush forces the 425 mA limit
  pci_drive_t next_drive;
  logic [7:0] next_lim;
  always_comb begin
    next_drive.det_run = (next_state == S_DETECT);
    next_drive.class_probe = (next_state == S_CLASS1 ||
        next_state == S_CLASS2); // see R4
    next_drive.mark_voltage = (next_state == S_MARK); // see R10
    next_drive.gate_on = (next_state == S_INRUSH ||
        next_state == S_POWERED); // see R16
    // regulate only while inrush current sits at the limit, see R16
    next_drive.gate_regulate = (next_state == S_INRUSH) && pf.over_inrush;
    next_drive.rsense_large = next_ctrl.rsense_large;
    next_lim = (next_state == S_INRUSH) ? (next_ctrl.rsense_large ?
        LIM_425_R50 : LIM_425_R25) : next_thresh[15:8];
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive <= '0;
      overcurrent_cut_threshold <= 8'h00;
      active_current_limit_threshold <= 8'h00;
    end else begin
      drive <= next_drive;
      overcurrent_cut_threshold <= next_thresh[7:0];
      active_current_limit_threshold <= next_lim;
    end
  end

  // ---- assertions
  property p_legacy_off;
    @(posedge aclk) $rose(aresetn) |-> !ctrl.legacy_en;
  endproperty
  a_legacy_off: assert property (p_legacy_off) else $error("legacy on"); // see R1
  property p_det_bad;
    @(posedge aclk) disable iff (!aresetn)
    (state == S_DETECT && det_evt && !pf.sig_valid && !(ctrl.legacy_en &&
        pf.sig_legacy)) |=> det_res == DET_BAD;
  endproperty
  a_det_bad: assert property (p_det_bad) else $error("bad detect as good"); // see R2
  property p_class_after;
    @(posedge aclk) disable iff (!aresetn)
    (state == S_DETECT && det_evt && good && cls_active && !cmd[CMD_OFF]
        && !cmd[CMD_ON] && ctrl.mode != MODE_MAN) |=> state == S_CLASS1
        ##1 drive.class_probe;
  endproperty
  a_class_after: assert property (p_class_after) else $error("no class run"); // see R3
  property p_class_store;
    @(posedge aclk) disable iff (!aresetn)
    (state == S_CLASS2 && tmr_done) |=> cls_f == $past(pf.class_code);
  endproperty
  a_class_store: assert property (p_class_store) else $error("class lost"); // see R15
  property p_class_gate;
    @(posedge aclk) disable iff (!aresetn)
    !cls_active |=> state != S_CLASS1 || $past(state) == S_CLASS1;
  endproperty
  a_class_gate: assert property (p_class_gate) else $error("class ran"); // see R7
  property p_mark;
    @(posedge aclk) disable iff (!aresetn)
    state == S_MARK |-> TWO_EVENT && cls_f == CLS_4 ##1 drive.mark_voltage
        || state != S_MARK;
  endproperty
  a_mark: assert property (p_mark) else $error("bad mark entry"); // see R13
  property p_second_flag;
    @(posedge aclk) disable iff (!aresetn)
    $rose(state == S_CLASS2) |-> second;
  endproperty
  a_second_flag: assert property (p_second_flag) else $error("no flag"); // see R11
  property p_invalid_pair;
    @(posedge aclk) disable iff (!aresetn)
    (state == S_CLASS2 && tmr_done && auto_mode && pf.class_code != CLS_4
        && !cmd[CMD_OFF]) |=> state == S_BACKOFF ##1 !drive.gate_on;
  endproperty
  a_invalid_pair: assert property (p_invalid_pair) else $error("powered"); // see R14
  property p_start_fault;
    @(posedge aclk) disable iff (!aresetn)
    (state == S_INRUSH && tmr_done && pf.over_inrush) |=> fault
        && !drive.gate_on;
  endproperty
  a_start_fault: assert property (p_start_fault) else $error("no fault"); // see R17
  property p_thr_write;
    @(posedge aclk) disable iff (!aresetn)
    (wr_fire && aw_q == REG_THRESH && strb_q[0] && !load_thr) |=>
        thresh[7:0] == $past(w_q[7:0]) ##1 overcurrent_cut_threshold ==
        $past(thresh[7:0]);
  endproperty
  a_thr_write: assert property (p_thr_write) else $error("write lost"); // see R9
  c_two_event: cover property (@(posedge aclk) state == S_MARK
      ##1 state == S_MARK);
  c_powered: cover property (@(posedge aclk) state == S_POWERED);
  c_fault: cover property (@(posedge aclk) $rose(fault));
endmodule // pci_port

// ---- hdl/pci_pkg.sv ----
// Contract
// R1: legacy recognition off at reset, per-port switchable
// R2: legacy on accepts big capacitance or valid signature
// R3: classify after good detect; manual only on command
// R4: apply class probe for interval, store class
// R5: five classes; class 0 handled as class 3
// R6: automatic mode loads thresholds from class result
// R7: no classification: strap low, shutdown, enable clear
// R8: second event only in higher-power variant
// R9: thresholds writable while port is powered
// R10: class 4 first: mark voltage, pause, reclassify
// R11: flag set whenever second event ran
// R12: second event needs its enable bit set
// R13: second event only after first class 4
// R14: class 4 then 0-3 withholds power, restarts
// R15: class field holds latest measurement
// R16: gate ramps, regulates at inrush limit, rises fully
// R17: start timer; still over limit means fault, off
// R18: both sense resistors; larger default in compat
// R19: manual mode idles, one detection per command
// R20: class field binary with unknown code
package pci_pkg;
  // clock rate and printed times
  localparam int CLK_MHZ = 50;
  localparam int CLASS_TIME_US = 12000;
  localparam int MARK_TIME_US = 5000;
  localparam int TSTART_US = 60000;
  localparam int BACKOFF_US = 100000;
  localparam int TMR_W = 23;
  localparam int STRAP_WAIT = 3;

  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_THRESH = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_HPSTAT = 8'h10;
  localparam logic [7:0] REG_INFO = 8'h14;

  // operating modes
  localparam logic [1:0] MODE_SHUT = 2'h0;
  localparam logic [1:0] MODE_MAN = 2'h1;
  localparam logic [1:0] MODE_SEMI = 2'h2;
  localparam logic [1:0] MODE_AUTO = 2'h3;

  // command bits, status fields, codes
  localparam int CMD_DET = 0;
  localparam int CMD_CLS = 1;
  localparam int CMD_ON = 2;
  localparam int CMD_OFF = 3;
  localparam int ST_POWER_BIT = 8;
  localparam int ST_FAULT_BIT = 9;
  localparam logic [2:0] DET_UNKNOWN = 3'h0;
  localparam logic [2:0] DET_BAD = 3'h2;
  localparam logic [2:0] DET_GOOD = 3'h4;
  localparam logic [2:0] CLS_UNKNOWN = 3'h7;
  localparam logic [2:0] CLS_1 = 3'h1;
  localparam logic [2:0] CLS_2 = 3'h2;
  localparam logic [2:0] CLS_4 = 3'h4;

  // current limit codes per sense resistor
  localparam logic [7:0] LIM_425_R50 = 8'h00;
  localparam logic [7:0] LIM_425_R25 = 8'h80;
  localparam logic [7:0] LIM_850_R50 = 8'h40;
  localparam logic [7:0] LIM_850_R25 = 8'hC0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // software control word
  typedef struct packed {
    logic rsense_large;
    logic hp_en;
    logic legacy_en;
    logic cls_en;
    logic det_en;
    logic [1:0] mode;
  } pci_ctrl_t;

  // filtered pin inputs
  typedef struct packed {
    logic [2:0] class_code;
    logic auto_pin;
    logic over_inrush;
    logic sig_legacy;
    logic sig_valid;
    logic det_done;
  } pci_pins_t;

  // analog front end drive
  typedef struct packed {
    logic det_run;
    logic class_probe;
    logic mark_voltage;
    logic gate_on;
    logic gate_regulate;
    logic rsense_large;
  } pci_drive_t;
endpackage

// ---- testbench/pci_pd_model.sv ----
`timescale 1ns/1ps
module pci_pd_model import pci_pkg::*; (
  // clock and front end
  input wire logic aclk,
  input wire pci_drive_t drive,
  input wire logic auto_pin,
  output pci_pins_t pins,
  // behaviour picked by the bench
  input wire logic present,
  input wire logic legacy,
  input wire logic stuck,
  input wire logic [2:0] cls1,
  input wire logic [2:0] cls2
);
  logic [3:0] dcnt = 4'h0;
  logic [3:0] icnt = 4'h0;
  logic second = 1'b0;
  logic [2:0] last = 3'h0;
  initial pins = '0;
  // powered device answers only while the port drives it
  always @(posedge aclk) begin
    dcnt <= drive.det_run ? dcnt + {3'h0, dcnt != 4'hF} : 4'h0;
    icnt <= drive.gate_on ? icnt + {3'h0, icnt != 4'hF} : 4'h0;
    if (drive.det_run) begin
      second <= 1'b0;
    end else if (drive.mark_voltage) begin
      second <= 1'b1;
    end
    pins.auto_pin <= auto_pin;
    pins.det_done <= dcnt > 4'h5;
    // signature lines wander outside a detection window
    pins.sig_valid <= dcnt > 4'h5 ? present : ~pins.sig_valid;
    pins.sig_legacy <= dcnt > 4'h5 ? legacy : ~pins.sig_legacy;
    if (drive.class_probe) begin
      pins.class_code <= second ? cls2 : cls1;
      last <= second ? cls2 : cls1;
    end else begin
      pins.class_code <= ~last; // no stale class when unprobed
    end
    // charging draws inrush briefly; stuck keeps it up
    pins.over_inrush <= drive.gate_on && (stuck || icnt < 4'h6);
  end
endmodule // pci_pd_model

// ---- testbench/pse_port_class_inrush_control_bench.sv ----
`timescale 1ns/1ps
module pse_port_class_inrush_control_bench import pci_pkg::*;;
  localparam int TS = 30;
  // cut codes equal to the design's defaults, index is class
  localparam logic [7:0] CUTS [5] = '{8'h30, 8'h10, 8'h20, 8'h30, 8'h50};
  logic aclk = 1'b0, aresetn = 1'b0, auto_pin = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rd_data;
  logic [1:0] rd_resp;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  pci_pins_t pins;
  pci_drive_t drive;
  logic [7:0] cut, lim, lim_in;
  logic present = 1'b0, legacy = 1'b0, stuck = 1'b0;
  logic [2:0] cls1 = 3'h1, cls2 = 3'h1;
  logic p_probe = 1'b0, p_det = 1'b0, p_gate = 1'b0;
  int probes = 0, dets = 0, gates = 0, cycles = 0;
  int miscompares = 0, compares = 0;

  pci_port #(.CLASS_CYC(20), .MARK_CYC(10), .TSTART_CYC(TS),
    .BACKOFF_CYC(15)) dut_u (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .pins(pins), .drive(drive), .overcurrent_cut_threshold(cut),
    .active_current_limit_threshold(lim));

  pci_pd_model pd_u (.aclk(aclk), .drive(drive), .auto_pin(auto_pin),
    .pins(pins), .present(present), .legacy(legacy), .stuck(stuck),
    .cls1(cls1), .cls2(cls2));

  initial begin
    forever #10 aclk = ~aclk;
  end

  // event counters and a hang guard
  always @(posedge aclk) begin
    p_probe <= drive.class_probe;
    p_det <= drive.det_run;
    p_gate <= drive.gate_on;
    if (drive.det_run && !p_det) begin
      probes <= 0;
      dets <= dets + 1;
    end else if (drive.class_probe && !p_probe) begin
      probes <= probes + 1;
    end
    if (drive.gate_on && !p_gate) gates <= gates + 1;
    if (drive.gate_regulate) lim_in <= lim;
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      miscompares++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] got, exp, input string msg);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, msg, got,
        exp);
    end
  endtask

  // axi4-lite write: address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (!rvalid);
    rd_data = rdata;
    rd_resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic rst(input logic strap);
    auto_pin <= strap;
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (8) @(posedge aclk);
  endtask

  // bounded wait for the gate to reach a level
  task automatic wgate(input logic v, input int n);
    for (int i = 0; i < n && drive.gate_on !== v; i++) @(posedge aclk);
    chk(drive.gate_on, v, "gate level");
  endtask

  // bounded wait for a count of fresh detection runs to finish
  task automatic wdet(input int n);
    int d0;
    d0 = dets;
    for (int i = 0; i < 2000 && (dets < d0 + n || drive.det_run); i++)
      @(posedge aclk);
    chk(dets, d0 + n, "detections");
  endtask

  // strap low: manual detection, legacy switch, no classification
  task automatic t_manual();
    rst(1'b0);
    rd(REG_CTRL);
    chk(rd_data, 32'h0, "ctrl reset");
    chk(drive.rsense_large, 1'b0, "small sense default");
    rd(REG_STATUS);
    chk(rd_data[6:4], CLS_UNKNOWN, "class reset");
    rd(8'h1C);
    chk(rd_resp, RESP_SLVERR, "unmapped");
    legacy <= 1'b1;
    wr(REG_CTRL, 32'h0000000D);
    wr(REG_CMD, 32'h00000001);
    wdet(1);
    rd(REG_STATUS);
    chk(rd_data[2:0], DET_BAD, "legacy off");
    repeat (100) @(posedge aclk);
    chk(drive.det_run, 1'b0, "manual idle");
    wr(REG_CTRL, 32'h0000001D);
    wr(REG_CMD, 32'h00000001);
    wdet(1);
    rd(REG_STATUS);
    chk(rd_data[2:0], DET_GOOD, "legacy on");
    wr(REG_CMD, 32'h00000002);
    repeat (60) @(posedge aclk);
    chk(probes, 0, "strap low class");
  endtask

  // class 4 twice with two-event on: powered, thresholds from class
  task automatic t_ping();
    rst(1'b1);
    wr(REG_CTRL, 32'h0000002F);
    rd(REG_INFO);
    chk(rd_data[1:0], 2'h3, "info");
    {cls1, cls2, present} <= {CLS_4, CLS_4, 1'b1};
    wgate(1'b1, 1500);
    chk(probes, 2, "two events");
    repeat (TS + 5) @(posedge aclk);
    rd(REG_STATUS);
    chk(rd_data[9:4], 6'h14, "powered class 4");
    chk(lim_in, LIM_425_R25, "inrush limit");
    chk({cut, lim}, {CUTS[4], LIM_850_R25}, "auto thr");
    rd(REG_HPSTAT);
    chk(rd_data[0], 1'b1, "second flag");
    wr(REG_THRESH, 32'h00001234);
    chk({lim, cut}, 16'h1234, "live thr");
  endtask

  // class 4 then class 2: power withheld, detection restarts
  task automatic t_invalid();
    int g0;
    wr(REG_HPSTAT, 32'h00000001);
    cls2 <= CLS_2;
    wr(REG_CMD, 32'h00000008);
    g0 = gates;
    wdet(2);
    chk(gates, g0, "no power");
    rd(REG_STATUS);
    chk(rd_data[6:4], CLS_2, "last class");
    rd(REG_HPSTAT);
    chk(rd_data[0], 1'b1, "second flag");
  endtask

  // every class, two-event off: one probe, thresholds per class
  task automatic t_classes();
    wr(REG_CTRL, 32'h0000000F);
    wr(REG_CMD, 32'h00000008);
    for (int c = 0; c < 5; c++) begin
      {cls1, cls2} <= {c[2:0], c[2:0]};
      wdet(1);
      wgate(1'b1, 1500);
      chk(probes, 1, "one event");
      repeat (TS + 5) @(posedge aclk);
      rd(REG_STATUS);
      chk(rd_data[6:4], c[2:0], "class");
      chk({cut, lim}, {CUTS[c], c == 4 ? LIM_850_R25 : LIM_425_R25},
        "class thr");
      wr(REG_CMD, 32'h00000008);
      wgate(1'b0, 10);
    end
  endtask

  // inrush never ends: gate off and start fault after the timer
  task automatic t_fault();
    {stuck, cls1} <= {1'b1, CLS_1};
    wgate(1'b1, 1500);
    repeat (TS + 5) @(posedge aclk);
    chk(drive.gate_on, 1'b0, "fault off");
    rd(REG_STATUS);
    chk(rd_data[9:8], 2'h2, "start fault");
    wr(REG_STATUS, 32'h00000200);
    rd(REG_STATUS);
    chk(rd_data[9], 1'b0, "fault clear");
  endtask

  // semi mode: host turns the port on, larger sense resistor limit
  task automatic t_semi();
    stuck <= 1'b0;
    wr(REG_CTRL, 32'h0000004E);
    wr(REG_CMD, 32'h00000004);
    chk({drive.rsense_large, lim}, {1'b1, LIM_425_R50}, "semi on");
    wgate(1'b1, 1);
  endtask

  task automatic summarize();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    t_manual();
    t_ping();
    t_invalid();
    t_classes();
    t_fault();
    t_semi();
    summarize();
  end
endmodule // pse_port_class_inrush_control_bench
